// ==== logic/evlog_pkg.sv ====
package evlog_pkg;
  // Register word indices; the byte address is four times the index.
  localparam logic [15:0] IDX_STATUS = 16'hA489;
  localparam logic [15:0] IDX_HDR_REQ = 16'hA48A;
  localparam logic [15:0] IDX_SMP_SEL = 16'hA48B;
  localparam logic [15:0] IDX_HIST_IDX = 16'hA48C;
  localparam logic [15:0] IDX_HIST_CNT = 16'hA48D;
  localparam logic [15:0] IDX_HIST_LOAD = 16'hA48E;
  localparam logic [15:0] IDX_FC_REQ = 16'hA491;
  localparam logic [15:0] IDX_BUF = 16'hA494;
  // Read buffer geometry.
  localparam int BUF_WORDS = 64;
  localparam logic [6:0] BUF_WORDS_W = 7'h40;
  // Fault log geometry.
  localparam int FAULTS = 64;
  localparam int STAMPS = 6;
  localparam logic [2:0] STAMPS_W = 3'h6;
  localparam logic [15:0] COUNT_MAX = 16'hFFFE;
  // Words loaded by each header or history request.
  localparam logic [6:0] HDR_WORDS = 7'h0C;
  localparam logic [6:0] HIST_WORDS = 7'h18;
  // Logger status codes.
  localparam logic [15:0] ST_IDLE = 16'h0000;
  localparam logic [15:0] ST_WAIT = 16'h0001;
  localparam logic [15:0] ST_CAPT = 16'h0002;
  localparam logic [15:0] ST_DONE = 16'h0003;
  // Value that launches a header or history load.
  localparam logic [15:0] GO_VALUE = 16'h0001;
  // Reset values.
  localparam logic [31:0] RD_RESET = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    EVLOG_SRC_HDR,
    EVLOG_SRC_SMP,
    EVLOG_SRC_FC,
    EVLOG_SRC_HIST
  } evlog_src_type;

  typedef enum logic [1:0] {
    EVLOG_IDLE,
    EVLOG_ADDR,
    EVLOG_CAPT
  } evlog_state_type;
endpackage : evlog_pkg

// ==== logic/evlog_readout.sv ====
`timescale 1ns/1ps
// Functional notes
// RQ1: Status reads 1 while awaiting trigger, 2 while capturing.
// RQ2: Status reads 3 once capture is complete and readable.
// RQ3: Writing 1 to header request loads header into buffer words 0 to 11.
// RQ4: Header words 0-3 are trigger time then date, high word first.
// RQ5: Header words 4-7 carry the mask as 31:16, 15:0, 63:48, 47:32.
// RQ6: Header words 8-11: sample count, words per sample, period, post-trigger count.
// RQ7: Writing a sample number loads that sample's words into the buffer.
// RQ8: Samples are numbered oldest first; last ones follow the trigger.
// RQ9: Fault index 0-31 is main status bits, 32-63 factory status bits.
// RQ10: One 16-bit counter per fault, incremented on each new occurrence.
// RQ11: Counters saturate at their maximum and hold there; the code holds them at COUNT_MAX, 0xFFFE.
// RQ12: Count request low byte is first index, high byte is how many.
// RQ13: Requested counts fill the buffer from word 0 in ascending index order.
// RQ14: Request 0x4000 returns all 64 counters in buffer words 0 to 63.
// RQ15: Each fault keeps date and time of its six latest occurrences.
// RQ16: History index selects a fault; entry count shows its 0 to 6 stamps.
// RQ17: Writing 1 to history load copies the selected stamps into the buffer.
// RQ18: Six slots are always loaded; entry count tells which are valid.
// RQ19: Slot is date MSW, date LSW, time MSW, time LSW; oldest first.
// RQ20: Buffer is read-only and holds until the next load replaces it.
module evlog_readout #(
  parameter int SMP_WORD_W = 6
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic log_waiting,
  input wire logic log_capturing,
  input wire logic log_complete,
  input wire logic [31:0] trig_time,
  input wire logic [31:0] trig_date,
  input wire logic [63:0] var_select,
  input wire logic [15:0] sample_count,
  input wire logic [15:0] words_per_sample,
  input wire logic [15:0] sample_period_ms,
  input wire logic [15:0] post_trig_samples,
  output logic sample_rd_en,
  output logic [15:0] sample_rd_index,
  output logic [SMP_WORD_W-1:0] sample_rd_word,
  input wire logic [15:0] sample_rd_data,
  input wire logic [31:0] main_fault_status,
  input wire logic [31:0] factory_fault_status,
  input wire logic [31:0] now_date,
  input wire logic [31:0] now_time
);
  logic hready_reg;
  logic [31:0] hrdata_reg;
  logic wr_pend_reg;
  logic [15:0] wr_idx_reg;
  logic [15:0] buf_reg [0:evlog_pkg::BUF_WORDS-1];
  logic [15:0] cnt_reg [0:evlog_pkg::FAULTS-1];
  logic [2:0] hist_cnt_reg [0:evlog_pkg::FAULTS-1];
  logic [2:0] hist_ptr_reg [0:evlog_pkg::FAULTS-1];
  logic [63:0] stamp_mem [0:evlog_pkg::FAULTS*evlog_pkg::STAMPS-1];
  logic [63:0] fault_prev_reg;
  logic [5:0] hist_idx_reg;
  logic [15:0] sel_smp_reg;
  logic [5:0] fc_start_reg;
  evlog_pkg::evlog_src_type src_reg;
  evlog_pkg::evlog_state_type state_reg;
  logic [6:0] k_reg;
  logic [6:0] len_reg;
  logic smp_en_reg;
  logic [15:0] smp_idx_reg;
  logic [SMP_WORD_W-1:0] smp_word_reg;

  // Address phase and write decode.
  wire addr_ok = hsel && htrans[1] && hready;
  wire [15:0] a_idx = haddr[17:2];
  wire a_high_zero = (haddr[31:18] == 14'h0000);
  wire [15:0] a_off = a_idx - evlog_pkg::IDX_BUF;
  wire a_in_buf = a_high_zero && (a_idx >= evlog_pkg::IDX_BUF) &&
    (a_off < 16'(evlog_pkg::BUF_WORDS));
  wire wr_fire = wr_pend_reg && hready_reg;
  wire [15:0] wdat = hwdata[15:0];
  wire wr_hdr = wr_fire && (wr_idx_reg == evlog_pkg::IDX_HDR_REQ) &&
    (wdat == evlog_pkg::GO_VALUE);
  wire wr_smp = wr_fire && (wr_idx_reg == evlog_pkg::IDX_SMP_SEL);
  wire wr_hidx = wr_fire && (wr_idx_reg == evlog_pkg::IDX_HIST_IDX);
  wire wr_hload = wr_fire && (wr_idx_reg == evlog_pkg::IDX_HIST_LOAD) &&
    (wdat == evlog_pkg::GO_VALUE);
  wire wr_fc = wr_fire && (wr_idx_reg == evlog_pkg::IDX_FC_REQ);
  wire [6:0] wps_cap = (words_per_sample > 16'(evlog_pkg::BUF_WORDS)) ?
    evlog_pkg::BUF_WORDS_W : words_per_sample[6:0];
  // RQ12: Request field split.
  wire [6:0] fc_len = (wdat[15:8] > 8'(evlog_pkg::BUF_WORDS)) ?
    evlog_pkg::BUF_WORDS_W : wdat[14:8];
  wire launch = wr_hdr || wr_smp || wr_hload || (wr_fc && (fc_len != 7'h00));
  wire load_last = (state_reg == evlog_pkg::EVLOG_CAPT) && (k_reg + 7'h01 >= len_reg);

  // Logger status from the capture engine.
  wire [15:0] status_word =
    // RQ2: Complete reads three.
    log_complete ? evlog_pkg::ST_DONE :
    // RQ1: Waiting or capturing.
    log_capturing ? evlog_pkg::ST_CAPT :
    log_waiting ? evlog_pkg::ST_WAIT : evlog_pkg::ST_IDLE;

  // Read data selection for the address being taken.
  wire [15:0] rd_word =
    a_in_buf ? buf_reg[a_off[5:0]] :
    !a_high_zero ? evlog_pkg::WORD_RESET :
    (a_idx == evlog_pkg::IDX_STATUS) ? status_word :
    (a_idx == evlog_pkg::IDX_HIST_IDX) ? {10'h000, hist_idx_reg} :
    // RQ16: Entry count of selection.
    (a_idx == evlog_pkg::IDX_HIST_CNT) ? {13'h0000, hist_cnt_reg[hist_idx_reg]} :
    evlog_pkg::WORD_RESET;

  // History slot lookup, oldest first once the ring has wrapped.
  wire [2:0] slot = k_reg[4:2];
  wire [2:0] h_cnt = hist_cnt_reg[hist_idx_reg];
  wire [2:0] h_ptr = hist_ptr_reg[hist_idx_reg];
  wire [3:0] rot = {1'b0, h_ptr} + {1'b0, slot};
  wire [2:0] phys = (h_cnt < evlog_pkg::STAMPS_W) ? slot :
    ((rot >= 4'h6) ? 3'(rot - 4'h6) : rot[2:0]);
  wire [8:0] h_addr = 9'(hist_idx_reg * evlog_pkg::STAMPS) + {6'h00, phys};
  wire [63:0] h_stamp = stamp_mem[h_addr];
  wire [5:0] fc_idx = fc_start_reg + k_reg[5:0];

  // Header word selection.
  wire [15:0] hdr_word =
    // RQ4: Time then date, high word first.
    (k_reg == 7'h00) ? trig_time[31:16] :
    (k_reg == 7'h01) ? trig_time[15:0] :
    (k_reg == 7'h02) ? trig_date[31:16] :
    (k_reg == 7'h03) ? trig_date[15:0] :
    // RQ5: Mask word order.
    (k_reg == 7'h04) ? var_select[31:16] :
    (k_reg == 7'h05) ? var_select[15:0] :
    (k_reg == 7'h06) ? var_select[63:48] :
    (k_reg == 7'h07) ? var_select[47:32] :
    // RQ6: Capture geometry words.
    (k_reg == 7'h08) ? sample_count :
    (k_reg == 7'h09) ? words_per_sample :
    (k_reg == 7'h0A) ? sample_period_ms : post_trig_samples;

  // Word captured into the buffer for the current step.
  wire [15:0] load_word =
    (src_reg == evlog_pkg::EVLOG_SRC_HDR) ? hdr_word :
    // RQ7: Sample words from the log memory.
    (src_reg == evlog_pkg::EVLOG_SRC_SMP) ? sample_rd_data :
    // RQ13: Ascending counter order.
    (src_reg == evlog_pkg::EVLOG_SRC_FC) ? cnt_reg[fc_idx] :
    // RQ19: Date then time, high word first.
    (k_reg[1:0] == 2'h0) ? h_stamp[63:48] :
    (k_reg[1:0] == 2'h1) ? h_stamp[47:32] :
    (k_reg[1:0] == 2'h2) ? h_stamp[31:16] : h_stamp[15:0];

  // RQ9: Fault index to status bit.
  wire [63:0] fault_now = {factory_fault_status, main_fault_status};
  wire [63:0] fault_rise = fault_now & ~fault_prev_reg;

  // Bus slave: read data is prepared at the address edge, writes land in the data phase.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata_reg <= evlog_pkg::RD_RESET;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= evlog_pkg::WORD_RESET;
    end else begin
      wr_pend_reg <= addr_ok && hwrite && hready_reg;
      if (addr_ok) begin
        wr_idx_reg <= a_high_zero ? a_idx : evlog_pkg::WORD_RESET;
        hrdata_reg <= hwrite ? evlog_pkg::RD_RESET : {16'h0000, rd_word};
      end
    end
  end

  // Bus stalls while a load runs so the buffer is never seen half filled.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hready_reg <= 1'b1;
    end else if (launch) begin
      hready_reg <= 1'b0;
    end else if (load_last || (state_reg == evlog_pkg::EVLOG_IDLE)) begin
      hready_reg <= 1'b1;
    end
  end

  // Selection registers written by software.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_idx_reg <= 6'h00;
      sel_smp_reg <= evlog_pkg::WORD_RESET;
      fc_start_reg <= 6'h00;
    end else begin
      // RQ16: Select a fault.
      if (wr_hidx) begin
        hist_idx_reg <= wdat[5:0];
      end
      if (wr_smp) begin
        sel_smp_reg <= wdat;
      end
      if (wr_fc) begin
        fc_start_reg <= wdat[5:0];
      end
    end
  end

  // Loader: one address step and one capture step per buffer word.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= evlog_pkg::EVLOG_IDLE;
      src_reg <= evlog_pkg::EVLOG_SRC_HDR;
      k_reg <= 7'h00;
      len_reg <= 7'h00;
    end else begin
      unique case (state_reg)
        evlog_pkg::EVLOG_IDLE: begin
          k_reg <= 7'h00;
          if (launch) begin
            state_reg <= evlog_pkg::EVLOG_ADDR;
            // RQ3: Header load request.
            if (wr_hdr) begin
              src_reg <= evlog_pkg::EVLOG_SRC_HDR;
              len_reg <= evlog_pkg::HDR_WORDS;
            end else if (wr_smp) begin
              src_reg <= evlog_pkg::EVLOG_SRC_SMP;
              len_reg <= wps_cap;
            end else if (wr_hload) begin
              // RQ18: Always six slots.
              src_reg <= evlog_pkg::EVLOG_SRC_HIST;
              len_reg <= evlog_pkg::HIST_WORDS;
            end else begin
              // RQ14: Count of up to 64.
              src_reg <= evlog_pkg::EVLOG_SRC_FC;
              len_reg <= fc_len;
            end
          end
        end
        evlog_pkg::EVLOG_ADDR: begin
          state_reg <= evlog_pkg::EVLOG_CAPT;
        end
        evlog_pkg::EVLOG_CAPT: begin
          k_reg <= k_reg + 7'h01;
          state_reg <= load_last ? evlog_pkg::EVLOG_IDLE : evlog_pkg::EVLOG_ADDR;
        end
      endcase
    end
  end

  // RQ8: Sample number passes straight through, oldest first.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      smp_en_reg <= 1'b0;
      smp_idx_reg <= evlog_pkg::WORD_RESET;
      smp_word_reg <= '0;
    end else begin
      smp_en_reg <= (state_reg == evlog_pkg::EVLOG_ADDR) &&
        (src_reg == evlog_pkg::EVLOG_SRC_SMP);
      smp_idx_reg <= sel_smp_reg;
      smp_word_reg <= k_reg[SMP_WORD_W-1:0];
    end
  end

  // RQ20: Buffer changes only on a capture step.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < evlog_pkg::BUF_WORDS; i++) begin
        buf_reg[i] <= evlog_pkg::WORD_RESET;
      end
    end else if (state_reg == evlog_pkg::EVLOG_CAPT) begin
      buf_reg[k_reg[5:0]] <= load_word;
    end
  end

  // Occurrence counters and time stamp rings, one entry per fault.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_prev_reg <= 64'h0000_0000_0000_0000;
      for (int f = 0; f < evlog_pkg::FAULTS; f++) begin
        cnt_reg[f] <= evlog_pkg::WORD_RESET;
        hist_cnt_reg[f] <= 3'h0;
        hist_ptr_reg[f] <= 3'h0;
      end
    end else begin
      fault_prev_reg <= fault_now;
      for (int f = 0; f < evlog_pkg::FAULTS; f++) begin
        if (fault_rise[f]) begin
          // RQ10: Count each occurrence.
          // RQ11: Saturate at COUNT_MAX, one below the 16-bit maximum.
          if (cnt_reg[f] < evlog_pkg::COUNT_MAX) begin
            cnt_reg[f] <= cnt_reg[f] + 16'h0001;
          end
          // RQ15: Keep six latest stamps.
          if (hist_cnt_reg[f] < evlog_pkg::STAMPS_W) begin
            hist_cnt_reg[f] <= hist_cnt_reg[f] + 3'h1;
          end else begin
            hist_ptr_reg[f] <= (hist_ptr_reg[f] == 3'h5) ? 3'h0 : hist_ptr_reg[f] + 3'h1;
          end
        end
      end
    end
  end

  // Stamp storage holds data only and needs no reset.
  always_ff @(posedge ref_clk) begin
    for (int f = 0; f < evlog_pkg::FAULTS; f++) begin
      if (fault_rise[f]) begin
        if (hist_cnt_reg[f] < evlog_pkg::STAMPS_W) begin
          stamp_mem[9'(f * evlog_pkg::STAMPS) + {6'h00, hist_cnt_reg[f]}] <=
            {now_date, now_time};
        end else begin
          stamp_mem[9'(f * evlog_pkg::STAMPS) + {6'h00, hist_ptr_reg[f]}] <=
            {now_date, now_time};
        end
      end
    end
  end

  // Outputs straight from flip-flops, except the response, which is tied to OKAY.
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign sample_rd_en = smp_en_reg;
  assign sample_rd_index = smp_idx_reg;
  assign sample_rd_word = smp_word_reg;
endmodule : evlog_readout

// ==== testbench/evlog_readout_assertions.sv ====
`timescale 1ns/1ps
// Checks bus answers and buffer load stalls of the readout block.
module evlog_readout_assertions (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic log_waiting,
  input wire logic log_capturing,
  input wire logic log_complete,
  input wire logic sample_rd_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // An accepted address phase, then a write data phase with a given value.
  sequence s_addr(logic w, logic [15:0] idx);
    hsel && htrans[1] && hready && hwrite == w && haddr == {14'h0, idx, 2'h0};
  endsequence
  sequence s_go(logic [15:0] idx, logic [15:0] v);
    s_addr(1'b1, idx) ##1 (hwdata[15:0] == v && hreadyout);
  endsequence
  property p_wait_code;
    s_addr(1'b0, evlog_pkg::IDX_STATUS) ##0 (log_waiting && !log_capturing && !log_complete)
      |=> hrdata == 32'h0000_0001;
  endproperty
  a_wait_code: assert property (p_wait_code) else $error("status not 1 while waiting");
  property p_done_code;
    s_addr(1'b0, evlog_pkg::IDX_STATUS) ##0 log_complete |=> hrdata == 32'h0000_0003;
  endproperty
  a_done_code: assert property (p_done_code) else $error("status not 3 when done");
  property p_hdr_stall;
    s_go(evlog_pkg::IDX_HDR_REQ, 16'h0001) |=> !hreadyout [*8] ##[16:18] hreadyout;
  endproperty
  a_hdr_stall: assert property (p_hdr_stall) else $error("header load length wrong");
  property p_hist_stall;
    s_go(evlog_pkg::IDX_HIST_LOAD, 16'h0001) |=> !hreadyout [*8] ##[40:42] hreadyout;
  endproperty
  a_hist_stall: assert property (p_hist_stall) else $error("history load length wrong");
  property p_all_stall;
    s_go(evlog_pkg::IDX_FC_REQ, 16'h4000) |=> !hreadyout [*8] ##[120:122] hreadyout;
  endproperty
  a_all_stall: assert property (p_all_stall) else $error("all count load length wrong");
  property p_one_stall;
    s_go(evlog_pkg::IDX_FC_REQ, 16'h0101) |=> !hreadyout ##1 !hreadyout ##[1:2] hreadyout;
  endproperty
  a_one_stall: assert property (p_one_stall) else $error("single count load wrong");
  property p_smp_busy;
    sample_rd_en |-> !hreadyout;
  endproperty
  a_smp_busy: assert property (p_smp_busy) else $error("sample fetch outside a load");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
endmodule : evlog_readout_assertions

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst_b, hsel, hwrite, hreadyout, hresp, sample_rd_en;
  logic log_waiting, log_capturing, log_complete;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, trig_time, trig_date, now_date, now_time;
  logic [31:0] main_fault_status, factory_fault_status;
  logic [63:0] var_select;
  logic [15:0] sample_count, words_per_sample, sample_period_ms, post_trig_samples;
  logic [15:0] sample_rd_index, sample_rd_data;
  logic [5:0] sample_rd_word;
  logic [31:0] v;
  logic [15:0] hdr [12];
  int bad_count, total_checks;
  evlog_readout #(.SMP_WORD_W(6)) uut (.ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .log_waiting,
    .log_capturing, .log_complete, .trig_time, .trig_date, .var_select, .sample_count,
    .words_per_sample, .sample_period_ms, .post_trig_samples, .sample_rd_en,
    .sample_rd_index, .sample_rd_word, .sample_rd_data, .main_fault_status,
    .factory_fault_status, .now_date, .now_time);
  // Clock of 100 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Sample memory stand-in: answers in the cycle of the request, as the loader captures then.
  assign sample_rd_data = (sample_rd_en === 1'b1) ? {sample_rd_index[9:0], sample_rd_word} :
    16'h0000;
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One single AHB transfer; the address phase holds until hready is seen high.
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : bus
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 16'h0000);
    check(v, exp);
  endtask : rd
  // One fault occurrence with its own date and time stamp.
  task automatic hit(input int b, input logic [31:0] d);
    @(posedge ref_clk);
    now_date <= d;
    now_time <= ~d;
    if (b < 32) main_fault_status[b] <= 1'b1;
    else factory_fault_status[b-32] <= 1'b1;
    @(posedge ref_clk);
    main_fault_status <= 32'h0000_0000;
    factory_fault_status <= 32'h0000_0000;
  endtask : hit
  // Watchdog far beyond the expected run length.
  initial begin
    #3000000;
    bad_count++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, log_capturing, log_complete} = '0;
    {main_fault_status, factory_fault_status, now_date, now_time} = '0;
    hsize = 3'h2;
    log_waiting = 1'b1;
    trig_time = 32'hA1A2_B1B2;
    trig_date = 32'hC1C2_D1D2;
    var_select = 64'h1111_2222_3333_4444;
    sample_count = 16'h0010;
    words_per_sample = 16'h0003;
    sample_period_ms = 16'h000A;
    post_trig_samples = 16'h0004;
    hdr = '{16'hA1A2, 16'hB1B2, 16'hC1C2, 16'hD1D2, 16'h3333, 16'h4444, 16'h1111,
      16'h2222, 16'h0010, 16'h0003, 16'h000A, 16'h0004};
    bad_count = 0;
    total_checks = 0;
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(evlog_pkg::IDX_STATUS, 32'h1);
    log_capturing <= 1'b1;
    rd(evlog_pkg::IDX_STATUS, 32'h2);
    log_complete <= 1'b1;
    rd(evlog_pkg::IDX_STATUS, 32'h3);
    bus(1'b1, evlog_pkg::IDX_HDR_REQ, 16'h0001);
    for (int i = 0; i < 12; i++) rd(evlog_pkg::IDX_BUF + 16'(i), {16'h0, hdr[i]});
    bus(1'b1, evlog_pkg::IDX_SMP_SEL, 16'h0005);
    for (int i = 0; i < 3; i++) rd(evlog_pkg::IDX_BUF + 16'(i), {26'h5, 6'(i)});
    bus(1'b1, evlog_pkg::IDX_BUF, 16'hFFFF);
    rd(evlog_pkg::IDX_BUF, 32'h0140);
    for (int k = 0; k < 3; k++) hit(1, 32'hD000_0000 + k);
    hit(32, 32'h7000_0000);
    hit(32, 32'h7000_0001);
    bus(1'b1, evlog_pkg::IDX_FC_REQ, 16'h0101);
    rd(evlog_pkg::IDX_BUF, 32'h3);
    bus(1'b1, evlog_pkg::IDX_FC_REQ, 16'h0220);
    rd(evlog_pkg::IDX_BUF, 32'h2);
    rd(evlog_pkg::IDX_BUF + 16'h1, 32'h0);
    bus(1'b1, evlog_pkg::IDX_FC_REQ, 16'h4000);
    rd(evlog_pkg::IDX_BUF + 16'h1, 32'h3);
    rd(evlog_pkg::IDX_BUF + 16'h20, 32'h2);
    bus(1'b1, evlog_pkg::IDX_HIST_IDX, 16'h0001);
    rd(evlog_pkg::IDX_HIST_IDX, 32'h1);
    rd(evlog_pkg::IDX_HIST_CNT, 32'h3);
    bus(1'b1, evlog_pkg::IDX_HIST_LOAD, 16'h0001);
    for (int k = 0; k < 3; k++) begin
      rd(evlog_pkg::IDX_BUF + 16'(4*k), 32'hD000);
      rd(evlog_pkg::IDX_BUF + 16'(4*k+1), 32'(k));
      rd(evlog_pkg::IDX_BUF + 16'(4*k+2), 32'h2FFF);
      rd(evlog_pkg::IDX_BUF + 16'(4*k+3), 32'hFFFF - 32'(k));
    end
    bus(1'b1, evlog_pkg::IDX_HIST_IDX, 16'h0000);
    rd(evlog_pkg::IDX_HIST_CNT, 32'h0);
    wrap_up();
  end
endmodule : testbench
bind evlog_readout evlog_readout_assertions u_chk (.ref_clk, .rst_b, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .log_waiting, .log_capturing,
  .log_complete, .sample_rd_en);
